// [hw/fsbdp_pkg.sv]
// fsbdp_pkg: shared constants of the front side bus data-phase link.
// assumes a 10 MHz mclk_i at the agent end; the bus clock is mclk_i / 16.
package fsbdp_pkg;

    // ========================================================================
    // bus geometry
    localparam int DATA_W = 64;                  // data bus width
    localparam int GRP_W  = 16;                  // one slice per strobe pair
    localparam int GRPS   = 4;                   // slices on the bus
    localparam int XFERS  = 4;                   // transfers per bus clock
    localparam int LANE_W = GRP_W + 2;           // slice plus invert and parity
    localparam int RX_W   = DATA_W * XFERS;      // one bus clock of data

    // ========================================================================
    // buffering
    localparam int FIFO_W     = DATA_W + 1;      // data plus last flag
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W    = 4;
    localparam logic [LEVEL_W-1:0] LEVEL_GROUP = 4'h4;

    // ========================================================================
    // timing: 16 mclk phases per bus clock
    localparam int MCLK_HZ = 10_000_000;
    localparam int BUS_DIV = 16;
    localparam int BUS_HZ  = MCLK_HZ / BUS_DIV;
    localparam logic [3:0] PH_LAST      = 4'hF;
    localparam logic [3:0] PH_BCLK_HIGH = 4'h8;  // bus clock high below this
    localparam logic [3:0] PH_SLOT0     = 4'h0;  // word launch phases
    localparam logic [3:0] PH_SLOT1     = 4'h3;
    localparam logic [3:0] PH_SLOT2     = 4'h6;
    localparam logic [3:0] PH_SLOT3     = 4'h9;
    localparam logic [3:0] PH_STB_A     = 4'h1;  // strobe edge phases
    localparam logic [3:0] PH_STB_B     = 4'h4;
    localparam logic [3:0] PH_STB_C     = 4'h7;
    localparam logic [3:0] PH_STB_D     = 4'hA;
    localparam logic [3:0] PH_STB_E     = 4'hD;

    // ========================================================================
    // coding
    localparam logic [4:0] INVERT_LIMIT = 5'h08;  // invert above half of 16

    // ========================================================================
    // reset values
    // last phase: first edge after reset raises bus_clk for a full 8-phase high
    localparam logic [3:0] PH_RESET = 4'hF;

    typedef enum logic [0:0] {
        BST_IDLE   = 1'b0,
        BST_ACTIVE = 1'b1
    } fsbdp_burst_e;

endpackage

// [hw/fsbdp_link_if.sv]
// fsbdp_link_if: the shared data-phase wires between agent and processor.
// assumes pull-ups on every active-low line; an undriven line reads high.
interface fsbdp_link_if;

    // ========================================================================
    // agent drive side
    logic                                         bus_clk;
    logic [fsbdp_pkg::DATA_W-1:0]                 data_bus_n_out;
    logic [fsbdp_pkg::GRPS-1:0]                   data_strobe_pos_n_out;
    logic [fsbdp_pkg::GRPS-1:0]                   data_strobe_neg_n_out;
    logic [fsbdp_pkg::GRPS-1:0]                   bus_invert_flag_n_out;
    logic [fsbdp_pkg::GRPS-1:0]                   data_parity_n_out;
    logic                                         data_oe;
    logic                                         data_ready_n_out;
    logic                                         data_bus_busy_n_out;
    logic                                         ctl_oe;
    logic                                         completion_a_n_out;
    logic                                         completion_oe;

    // ========================================================================
    // resolved wire levels
    logic [fsbdp_pkg::DATA_W-1:0]                 data_bus_n;
    logic [fsbdp_pkg::GRPS-1:0]                   data_strobe_pos_n;
    logic [fsbdp_pkg::GRPS-1:0]                   data_strobe_neg_n;
    logic [fsbdp_pkg::GRPS-1:0]                   bus_invert_flag_n;
    logic [fsbdp_pkg::GRPS-1:0]                   data_parity_n;
    logic                                         data_ready_n;
    logic                                         data_bus_busy_n;
    logic                                         completion_a_n;

    // pull-up when nobody drives
    assign data_bus_n        = data_oe ? data_bus_n_out : {fsbdp_pkg::DATA_W{1'b1}};
    assign data_strobe_pos_n = data_oe ? data_strobe_pos_n_out : {fsbdp_pkg::GRPS{1'b1}};
    assign data_strobe_neg_n = data_oe ? data_strobe_neg_n_out : {fsbdp_pkg::GRPS{1'b1}};
    assign bus_invert_flag_n = data_oe ? bus_invert_flag_n_out : {fsbdp_pkg::GRPS{1'b1}};
    assign data_parity_n     = data_oe ? data_parity_n_out : {fsbdp_pkg::GRPS{1'b1}};
    assign data_ready_n      = ctl_oe ? data_ready_n_out : 1'b1;
    assign data_bus_busy_n   = ctl_oe ? data_bus_busy_n_out : 1'b1;
    assign completion_a_n    = completion_oe ? completion_a_n_out : 1'b1;

    modport agent (
        output bus_clk, data_bus_n_out, data_strobe_pos_n_out, data_strobe_neg_n_out,
        output bus_invert_flag_n_out, data_parity_n_out, data_oe,
        output data_ready_n_out, data_bus_busy_n_out, ctl_oe,
        output completion_a_n_out, completion_oe
    );

    modport cpu (
        input bus_clk, data_bus_n, data_strobe_pos_n, data_strobe_neg_n,
        input bus_invert_flag_n, data_parity_n, data_ready_n, data_bus_busy_n, completion_a_n
    );

endinterface

// [hw/fsbdp_cpu_end.sv]
// fsbdp_cpu_end: processor end, receives quad-pumped data from the link.
// assumes the agent end makes bus_clk and launches data, strobes and
// handshakes at fixed mclk phases, so strobe-captured words are stable
// at the next rising bus clock.

// ============================================================================
// one slice: strobe capture and decode
module fsbdp_lane #(
    parameter int W = 16
) (
    input  wire logic           rst_i,
    input  wire logic           strobe_pos_n_i,
    input  wire logic           strobe_neg_n_i,
    input  wire logic [W-1:0]   data_n_i,
    input  wire logic           invert_n_i,
    input  wire logic           parity_n_i,
    output logic [4*W-1:0]      words_o,
    output logic [3:0]          err_o
);

    logic [W+1:0] pos_first;
    logic [W+1:0] pos_second;
    logic [W+1:0] neg_first;
    logic [W+1:0] neg_second;

    // restore true value and check even parity over the slice as driven
    function automatic logic [W:0] decode(input logic [W+1:0] cap);
        logic [W-1:0] sent;
        sent = ~cap[W-1:0];
        decode[W-1:0] = (!cap[W]) ? ~sent : sent;
        decode[W]     = (^sent) != (!cap[W+1]);
    endfunction

    // transfers 0 and 2 on the positive strobe falling edge
    always_ff @(negedge strobe_pos_n_i or posedge rst_i) begin
        if (rst_i) begin
            pos_first  <= '0;
            pos_second <= '0;
        end else begin
            pos_first  <= pos_second;
            pos_second <= {parity_n_i, invert_n_i, data_n_i};
        end
    end

    // transfers 1 and 3 on the negative strobe falling edge
    always_ff @(negedge strobe_neg_n_i or posedge rst_i) begin
        if (rst_i) begin
            neg_first  <= '0;
            neg_second <= '0;
        end else begin
            neg_first  <= neg_second;
            neg_second <= {parity_n_i, invert_n_i, data_n_i};
        end
    end

    // decoded words in transfer order
    logic [W:0] d0, d1, d2, d3;
    assign d0      = decode(pos_first);
    assign d1      = decode(neg_first);
    assign d2      = decode(pos_second);
    assign d3      = decode(neg_second);
    assign words_o = {d3[W-1:0], d2[W-1:0], d1[W-1:0], d0[W-1:0]};
    assign err_o   = {d3[W], d2[W], d1[W], d0[W]};

endmodule

// ============================================================================
// processor end top
module fsbdp_cpu_end (
    input  wire logic                        rst_i,
    fsbdp_link_if.cpu                        link,
    output logic                             rx_valid_o,
    output logic [fsbdp_pkg::RX_W-1:0]       rx_data_o,
    output logic                             rx_par_err_o,
    output logic                             bus_free_o,
    output logic                             deferred_o
);

    logic [fsbdp_pkg::GRP_W*4-1:0] lane_words [fsbdp_pkg::GRPS];
    logic [3:0]                    lane_err   [fsbdp_pkg::GRPS];
    logic [fsbdp_pkg::RX_W-1:0]    next_rx_data;
    logic                          next_err;

    // one lane per 16-bit slice, strobe pair of the same index
    for (genvar g = 0; g < fsbdp_pkg::GRPS; g++) begin : g_lane
        fsbdp_lane #(.W(fsbdp_pkg::GRP_W)) u_lane (
            .rst_i          (rst_i),
            .strobe_pos_n_i (link.data_strobe_pos_n[g]),
            .strobe_neg_n_i (link.data_strobe_neg_n[g]),
            .data_n_i       (link.data_bus_n[g*fsbdp_pkg::GRP_W +: fsbdp_pkg::GRP_W]),
            .invert_n_i     (link.bus_invert_flag_n[g]),
            .parity_n_i     (link.data_parity_n[g]),
            .words_o        (lane_words[g]),
            .err_o          (lane_err[g])
        );
    end

    // assemble four 64-bit transfers, transfer 0 lowest
    always_comb begin
        next_rx_data = '0;
        next_err     = 1'b0;
        for (int g = 0; g < fsbdp_pkg::GRPS; g++) begin
            for (int k = 0; k < fsbdp_pkg::XFERS; k++) begin
                next_rx_data[k*fsbdp_pkg::DATA_W + g*fsbdp_pkg::GRP_W +: fsbdp_pkg::GRP_W] =
                    lane_words[g][k*fsbdp_pkg::GRP_W +: fsbdp_pkg::GRP_W];
                next_err = next_err | lane_err[g][k];
            end
        end
    end

    // take a bus clock of data only when data ready was asserted
    always_ff @(posedge link.bus_clk or posedge rst_i) begin
        if (rst_i) begin
            rx_valid_o   <= 1'b0;
            rx_data_o    <= '0;
            rx_par_err_o <= 1'b0;
        end else begin
            rx_valid_o   <= !link.data_ready_n;
            rx_par_err_o <= !link.data_ready_n && next_err;
            if (!link.data_ready_n) begin
                rx_data_o <= next_rx_data;
            end
        end
    end

    // bus ownership and completion_a status
    always_ff @(posedge link.bus_clk or posedge rst_i) begin
        if (rst_i) begin
            bus_free_o <= 1'b0;
            deferred_o <= 1'b0;
        end else begin
            bus_free_o <= link.data_bus_busy_n;
            deferred_o <= !link.completion_a_n;
        end
    end

endmodule

// [hw/fsbdp_agent_end.sv]
// fsbdp_agent_end: chipset end, makes the bus clock and drives quad-pumped
// data from an 8-word FIFO onto the link.
// assumes a 10 MHz mclk_i and the processor end on the far side of the link.

// ============================================================================
// parameterised FIFO with registered input ready
module fsbdp_fifo #(
    parameter int W = 65,
    parameter int D = 8
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     in_valid_i,
    input  wire logic [W-1:0]             in_data_i,
    output logic                          in_ready_o,
    output logic                          out_valid_o,
    output logic [W-1:0]                  out_data_o,
    input  wire logic                     out_ready_i,
    output logic [$clog2(D):0]            level_o
);

    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    // depth must be a power of two: pointers wrap naturally
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;
    assign next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid_o = count != '0;
    assign out_data_o  = mem[rptr];
    assign level_o     = count;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    // pointers, level and ready
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr       <= '0;
            rptr       <= '0;
            count      <= '0;
            in_ready_o <= 1'b0;
        end else begin
            wptr       <= wptr + AW'(push);
            rptr       <= rptr + AW'(pop);
            count      <= next_count;
            in_ready_o <= next_count < (AW+1)'(D);
        end
    end

endmodule

// ============================================================================
// agent end top
module fsbdp_agent_end (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_i,
    input  wire logic [fsbdp_pkg::DATA_W-1:0]  tx_data_i,
    input  wire logic                          tx_last_i,
    input  wire logic                          tx_valid_i,
    output logic                               tx_ready_o,
    input  wire logic                          completion_a_i,
    output logic                               busy_o,
    fsbdp_link_if.agent                        link
);

    fsbdp_pkg::fsbdp_burst_e             state;
    fsbdp_pkg::fsbdp_burst_e             next_state;
    logic [3:0]                          ph;
    logic                                send;
    logic                                next_send;
    logic                                last_seen;
    logic                                at_slot;
    logic                                pop;
    logic                                fifo_valid;
    logic [fsbdp_pkg::FIFO_W-1:0]        fifo_data;
    logic [fsbdp_pkg::LEVEL_W-1:0]       level;

    // slice coding: {invert, sent slice}
    function automatic logic [fsbdp_pkg::GRP_W:0] encode(input logic [fsbdp_pkg::GRP_W-1:0] d);
        logic [4:0] ones;
        ones = '0;
        for (int i = 0; i < fsbdp_pkg::GRP_W; i++) begin
            ones = ones + {4'h0, d[i]};
        end
        if (ones > fsbdp_pkg::INVERT_LIMIT) begin
            encode = {1'b1, ~d};
        end else begin
            encode = {1'b0, d};
        end
    endfunction

    // ========================================================================
    // transmit buffer
    fsbdp_fifo #(.W(fsbdp_pkg::FIFO_W), .D(fsbdp_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i       (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   ({tx_last_i, tx_data_i}),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (pop),
        .level_o     (level)
    );

    // ========================================================================
    // bus clock divider: 16 mclk phases per bus clock
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ph           <= fsbdp_pkg::PH_RESET;
            link.bus_clk <= 1'b0;
        end else begin
            ph           <= ph + 4'h1;
            link.bus_clk <= (ph == fsbdp_pkg::PH_LAST) || ((ph + 4'h1) < fsbdp_pkg::PH_BCLK_HIGH);
        end
    end

    // ========================================================================
    // burst control, decided once per bus clock at phase 0
    always_comb begin
        next_state = state;
        next_send  = 1'b0;
        case (state)
            fsbdp_pkg::BST_IDLE: begin
                if (level >= fsbdp_pkg::LEVEL_GROUP) begin
                    next_state = fsbdp_pkg::BST_ACTIVE;
                    next_send  = 1'b1;
                end
            end
            fsbdp_pkg::BST_ACTIVE: begin
                if (last_seen) begin
                    next_state = fsbdp_pkg::BST_IDLE;
                end else begin
                    next_send = level >= fsbdp_pkg::LEVEL_GROUP;
                end
            end
            default: begin
                next_state = fsbdp_pkg::BST_IDLE;
            end
        endcase
    end

    // word launch slots within a data clock
    assign at_slot = (ph == fsbdp_pkg::PH_SLOT0 && next_send) ||
                     (send && (ph == fsbdp_pkg::PH_SLOT1 || ph == fsbdp_pkg::PH_SLOT2 ||
                               ph == fsbdp_pkg::PH_SLOT3));
    assign pop     = at_slot && fifo_valid;

    // state, handshakes and enables at the bus clock boundary
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state                    <= fsbdp_pkg::BST_IDLE;
            send                     <= 1'b0;
            busy_o                   <= 1'b0;
            link.data_ready_n_out    <= 1'b1;
            link.data_bus_busy_n_out <= 1'b1;
            link.ctl_oe              <= 1'b0;
            link.data_oe             <= 1'b0;
        end else if (ph == fsbdp_pkg::PH_SLOT0) begin
            state                    <= next_state;
            send                     <= next_send;
            busy_o                   <= next_state == fsbdp_pkg::BST_ACTIVE;
            link.data_ready_n_out    <= !next_send;
            link.data_bus_busy_n_out <= next_state != fsbdp_pkg::BST_ACTIVE;
            link.ctl_oe              <= next_state == fsbdp_pkg::BST_ACTIVE;
            link.data_oe             <= next_state == fsbdp_pkg::BST_ACTIVE;
        end
    end

    // end of burst: last flag on the fourth word of a clock
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            last_seen <= 1'b0;
        end else if (ph == fsbdp_pkg::PH_SLOT0) begin
            last_seen <= 1'b0;
        end else if (pop && ph == fsbdp_pkg::PH_SLOT3) begin
            last_seen <= fifo_data[fsbdp_pkg::DATA_W];
        end
    end

    // ========================================================================
    // data, inversion and parity per slice, one word per slot
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link.data_bus_n_out        <= {fsbdp_pkg::DATA_W{1'b1}};
            link.bus_invert_flag_n_out <= {fsbdp_pkg::GRPS{1'b1}};
            link.data_parity_n_out     <= {fsbdp_pkg::GRPS{1'b1}};
        end else if (pop) begin
            for (int g = 0; g < fsbdp_pkg::GRPS; g++) begin
                logic [fsbdp_pkg::GRP_W:0] c;
                c = encode(fifo_data[g*fsbdp_pkg::GRP_W +: fsbdp_pkg::GRP_W]);
                link.data_bus_n_out[g*fsbdp_pkg::GRP_W +: fsbdp_pkg::GRP_W] <= ~c[fsbdp_pkg::GRP_W-1:0];
                link.bus_invert_flag_n_out[g] <= !c[fsbdp_pkg::GRP_W];
                link.data_parity_n_out[g]     <= !(^c[fsbdp_pkg::GRP_W-1:0]);
            end
        end
    end

    // strobes: positive falls mid transfer 0 and 2, negative mid 1 and 3
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link.data_strobe_pos_n_out <= {fsbdp_pkg::GRPS{1'b1}};
            link.data_strobe_neg_n_out <= {fsbdp_pkg::GRPS{1'b1}};
        end else if (send) begin
            if (ph == fsbdp_pkg::PH_STB_A || ph == fsbdp_pkg::PH_STB_C) begin
                link.data_strobe_pos_n_out <= {fsbdp_pkg::GRPS{1'b0}};
            end else if (ph == fsbdp_pkg::PH_STB_B || ph == fsbdp_pkg::PH_STB_D) begin
                link.data_strobe_pos_n_out <= {fsbdp_pkg::GRPS{1'b1}};
            end
            if (ph == fsbdp_pkg::PH_STB_B || ph == fsbdp_pkg::PH_STB_D) begin
                link.data_strobe_neg_n_out <= {fsbdp_pkg::GRPS{1'b0}};
            end else if (ph == fsbdp_pkg::PH_STB_C || ph == fsbdp_pkg::PH_STB_E) begin
                link.data_strobe_neg_n_out <= {fsbdp_pkg::GRPS{1'b1}};
            end
        end
    end

    // ========================================================================
    // completion_a indication, driven only while asserted
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link.completion_a_n_out <= 1'b1;
            link.completion_oe      <= 1'b0;
        end else begin
            link.completion_a_n_out <= !completion_a_i;
            link.completion_oe      <= completion_a_i;
        end
    end

endmodule

// [bench/fsbdp_link_assertions.sv]
// fsbdp_link_assertions: timing and coding checks on the shared link wires.
// assumes mclk_i clocks the agent end and the wires come from the interface.
module fsbdp_link_assertions (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        completion_a_i,
    input wire logic        bus_clk,
    input wire logic [63:0] data_bus_n,
    input wire logic [3:0]  data_strobe_pos_n,
    input wire logic [3:0]  data_strobe_neg_n,
    input wire logic [3:0]  bus_invert_flag_n,
    input wire logic [3:0]  data_parity_n,
    input wire logic        data_ready_n,
    input wire logic        data_bus_busy_n,
    input wire logic        completion_a_n
);
    logic par_ok;
    logic inv_ok;

    // ====================
    // slice coding
    // parity and ones count of every slice as driven
    always_comb begin
        par_ok = 1'b1;
        inv_ok = 1'b1;
        for (int g = 0; g < 4; g++) begin
            if (^{data_bus_n[16*g +: 16], data_parity_n[g]} != 1'b1) par_ok = 1'b0;
            if ($countones(~data_bus_n[16*g +: 16]) > (bus_invert_flag_n[g] ? 8 : 7)) inv_ok = 1'b0;
        end
    end

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // ====================
    // assertions
    bus_clk_period_a: assert property ($rose(bus_clk) |-> bus_clk[*8] ##1 !bus_clk[*8])
        else $error("bus clock not eight high then eight low");
    strobe_order_a: assert property ($fell(data_strobe_pos_n[0]) |-> ##3 $fell(data_strobe_neg_n[0]))
        else $error("negative strobe fall not three phases after positive");
    strobe_pairs_a: assert property (data_strobe_pos_n == {4{data_strobe_pos_n[0]}}
        && data_strobe_neg_n == {4{data_strobe_neg_n[0]}}) else $error("strobe pairs out of step");
    invert_limit_a: assert property (!data_ready_n |-> inv_ok)
        else $error("slice sent with too many asserted bits");
    parity_even_a: assert property (!data_ready_n |-> par_ok)
        else $error("slice parity wrong");
    ready_busy_a: assert property (!data_ready_n |-> !data_bus_busy_n)
        else $error("data ready without busy");
    ready_held_a: assert property ($fell(data_ready_n) |-> !data_ready_n[*8] ##1 !data_ready_n[*7])
        else $error("data ready shorter than one bus clock");
    busy_gap_a: assert property ($rose(data_bus_busy_n) |-> data_bus_busy_n[*8] ##1 data_bus_busy_n[*7])
        else $error("bus reclaimed within one bus clock");
    completion_a_echo_a: assert property (completion_a_n == !$past(completion_a_i))
        else $error("completion_a line not following completion_a request");

    burst_c: cover property ($fell(data_bus_busy_n));
    invert_c: cover property (!data_ready_n && bus_invert_flag_n != 4'hF);
    completion_a_c: cover property ($fell(completion_a_n));
endmodule

// [bench/tb_top.sv]
// tb_top: feeds the agent end and checks words arriving at the cpu end.
// assumes the hw/ package, interface and both ends are compiled first.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t ns: got %h want %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic         mclk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic [63:0]  tx_data_i = 64'h0;
    logic         tx_last_i = 1'b0;
    logic         tx_valid_i = 1'b0;
    logic         completion_a_i = 1'b0;
    logic         tx_ready_o, busy_o, rx_valid_o, rx_par_err_o, bus_free_o, deferred_o;
    logic [255:0] rx_data_o;
    int           failures = 0, n_tests = 0, cyc = 0;
    logic [63:0]  w [8] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 64'h00FF_01FF_FFFE_8001, 64'h1234_5678_9ABC_DEF0,
        64'hA5A5_5A5A_FF00_0F0F, 64'hFFFF_0000_7FFF_0001, 64'h8000_FFF7_0101_3C3C, 64'hF0F0_0FF1_EEEE_0003};

    fsbdp_link_if fsbdp_link_if_inst ();
    fsbdp_agent_end fsbdp_agent_end_inst (.mclk_i, .rst_i, .tx_data_i, .tx_last_i, .tx_valid_i, .tx_ready_o,
        .completion_a_i, .busy_o, .link(fsbdp_link_if_inst));
    fsbdp_cpu_end fsbdp_cpu_end_inst (.rst_i, .link(fsbdp_link_if_inst), .rx_valid_o, .rx_data_o, .rx_par_err_o,
        .bus_free_o, .deferred_o);
    fsbdp_link_assertions fsbdp_link_assertions_inst (.mclk_i, .rst_i, .completion_a_i, .bus_clk(fsbdp_link_if_inst.bus_clk),
        .data_bus_n(fsbdp_link_if_inst.data_bus_n), .data_strobe_pos_n(fsbdp_link_if_inst.data_strobe_pos_n),
        .data_strobe_neg_n(fsbdp_link_if_inst.data_strobe_neg_n), .data_parity_n(fsbdp_link_if_inst.data_parity_n),
        .bus_invert_flag_n(fsbdp_link_if_inst.bus_invert_flag_n), .data_ready_n(fsbdp_link_if_inst.data_ready_n),
        .data_bus_busy_n(fsbdp_link_if_inst.data_bus_busy_n), .completion_a_n(fsbdp_link_if_inst.completion_a_n));

    // ====================
    // tasks
    // one word into the agent fifo, held until taken
    task automatic wr(input logic [63:0] d, input logic l);
        #1 tx_valid_i = 1'b1;
        tx_data_i = d;
        tx_last_i = l;
        @(posedge mclk_i);
        while (tx_ready_o !== 1'b1) @(posedge mclk_i);
    endtask

    // one bus clock of words at the cpu end
    // outputs move on a bus_clk rise; read them one mclk later, one data clock per call
    task automatic recv(input logic [255:0] exp);
        @(posedge fsbdp_link_if_inst.bus_clk);
        @(posedge mclk_i);
        while (rx_valid_o !== 1'b1) begin
            @(posedge fsbdp_link_if_inst.bus_clk);
            @(posedge mclk_i);
        end
        `CHK(rx_data_o, exp)
        `CHK(rx_par_err_o, 1'b0)
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ====================
    // clock, watchdog, sequence
    initial forever #50 mclk_i = ~mclk_i;

    // cut a hang short
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            $display("Error at %0t ns: timeout", $time);
            complete_run();
        end
    end

    // back-to-back burst, refusal when full, split burst, completion_a
    initial begin
        repeat (5) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) wr(w[i], i == 7);
        #1;
        `CHK(tx_ready_o, 1'b0)
        tx_valid_i = 1'b0;
        recv({w[3], w[2], w[1], w[0]});
        `CHK(bus_free_o, 1'b0)
        recv({w[7], w[6], w[5], w[4]});
        while (bus_free_o !== 1'b1) @(posedge mclk_i);
        `CHK(busy_o, 1'b0)
        for (int i = 4; i < 8; i++) wr(w[i], 1'b0);
        #1 tx_valid_i = 1'b0;
        recv({w[7], w[6], w[5], w[4]});
        for (int i = 0; i < 4; i++) wr(w[i], i == 3);
        #1 tx_valid_i = 1'b0;
        recv({w[3], w[2], w[1], w[0]});
        #1 completion_a_i = 1'b1;
        while (deferred_o !== 1'b1) @(posedge mclk_i);
        `CHK(fsbdp_link_if_inst.completion_a_n, 1'b0)
        #1 completion_a_i = 1'b0;
        while (deferred_o !== 1'b0) @(posedge mclk_i);
        `CHK(fsbdp_link_if_inst.completion_a_n, 1'b1)
        complete_run();
    end
endmodule
